// *** design/eep_pkg.sv ***
/*
   Shared constants and types for the read path of a two-wire serial EEPROM.
   Assumes one system clock domain plus the bus clock domain that the master drives.
*/
// Functional notes
// RULE1 - A read starts like a write: start, device address, direction bit 1.
// RULE2 - The word address counter holds the last accessed address plus one.
// RULE3 - The counter keeps its value across bus operations while powered.
// RULE4 - On read the counter wraps from the top of the array to zero.
// RULE5 - On write the counter wraps within the current page only.
// RULE6 - After a read address is acknowledged, the current byte goes out MSB first.
// RULE7 - The master ends a single read with no acknowledge and a stop.
// RULE8 - Random read: write-direction address then word address bytes, no data.
// RULE9 - After the word address the master sends a repeated start and read address.
// RULE10 - Random read returns the byte at the newly loaded address.
// RULE11 - A sequential read follows either read kind while the master acknowledges.
// RULE12 - Each master acknowledge increments the counter and sends the next byte.
// RULE13 - A sequential read wraps past the top to zero without a pause.
// RULE14 - The master ends a sequential read with no acknowledge and a stop.
// RULE15 - A device address byte holds a type code, three select bits and direction.
// RULE16 - The device acknowledges each received byte by pulling SDA low on clock nine.
// RULE17 - The word address is 14 or 15 bits, sent as two bytes.
// RULE18 - During an internal write cycle the device address gets no acknowledge.
// RULE19 - On a master no-acknowledge the device releases SDA and waits for start or stop.
// RULE20 - A select mismatch gets no acknowledge and the device idles until the next start.

`default_nettype none

package eep_pkg;

   // ***************************************************************
   // Address layout
   // ***************************************************************
   localparam int ADDR_W_DEF = 15;
   localparam int PAGE_BITS = 6;

   // ***************************************************************
   // Device address byte
   // ***************************************************************
   localparam logic [3:0] TYPE_CODE = 4'hA;
   localparam logic DIR_READ = 1'h1;

   // ***************************************************************
   // Bit positions inside a byte frame and timing counts
   // ***************************************************************
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [2:0] TX_BITS_LEFT = 3'h7;
   localparam logic [2:0] CLR_MIN_CYC = 3'h4;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_WHI,
      ST_WLO,
      ST_WDATA,
      ST_READ,
      ST_IGNORE
   } eep_state_t;

endpackage

`default_nettype wire

// *** design/eep_link_if.sv ***
/*
   Carrier between the system-clock protocol engine and the bus-clock receiver.
   Assumes the receiver is cleared by the engine and reports bytes by toggles.
*/
`default_nettype none

interface eep_link_if;
   logic linkClr;
   logic [7:0] rxByte;
   logic byteTgl;
   logic ninthTgl;
   logic ninthBit;

   modport sys (output linkClr, input rxByte, input byteTgl, input ninthTgl, input ninthBit);
   modport link (input linkClr, output rxByte, output byteTgl, output ninthTgl,
      output ninthBit);
endinterface

`default_nettype wire

// *** design/eep_link_rx.sv ***
/*
   Bus-clock receiver: samples SDA on each rising SCL edge and frames nine-bit slots.
   Assumes linkClr is a glitch-free register that is released while SCL is low.
*/
`default_nettype none

module eep_link_rx
(
   // Bus clock and data
   input wire logic sclClk,
   input wire logic sdaIn,
   // Toward the protocol engine
   eep_link_if.link lk
);

   logic [3:0] bitCnt_reg, bitCnt_next;
   logic [6:0] shift_reg, shift_next;
   logic [7:0] rxByte_reg, rxByte_next;
   logic byteTgl_reg, byteTgl_next;
   logic ninthTgl_reg, ninthTgl_next;
   logic ninthBit_reg, ninthBit_next;

   // ***************************************************************
   // Bit framing
   // ***************************************************************
   always_comb
   begin
      shift_next = {shift_reg[5:0], sdaIn};
      rxByte_next = rxByte_reg;
      byteTgl_next = byteTgl_reg;
      ninthTgl_next = ninthTgl_reg;
      ninthBit_next = ninthBit_reg;
      bitCnt_next = bitCnt_reg + 4'h1;
      if (bitCnt_reg == eep_pkg::LAST_DATA_BIT)
      begin
         rxByte_next = {shift_reg, sdaIn};   // [RULE15]
         byteTgl_next = ~byteTgl_reg;
      end
      if (bitCnt_reg == eep_pkg::ACK_BIT)
      begin
         ninthBit_next = sdaIn;
         ninthTgl_next = ~ninthTgl_reg;
         bitCnt_next = 4'h0;
      end
   end

   // The bus clock stops between frames, so the engine clears this logic directly.
   always_ff @(posedge sclClk or posedge lk.linkClr)
   begin
      if (lk.linkClr)
      begin
         bitCnt_reg <= 4'h0;
         shift_reg <= 7'h00;
         rxByte_reg <= 8'h00;
         byteTgl_reg <= 1'h0;
         ninthTgl_reg <= 1'h0;
         ninthBit_reg <= 1'h1;
      end
      else
      begin
         bitCnt_reg <= bitCnt_next;
         shift_reg <= shift_next;
         rxByte_reg <= rxByte_next;
         byteTgl_reg <= byteTgl_next;
         ninthTgl_reg <= ninthTgl_next;
         ninthBit_reg <= ninthBit_next;
      end
   end

   assign lk.rxByte = rxByte_reg;
   assign lk.byteTgl = byteTgl_reg;
   assign lk.ninthTgl = ninthTgl_reg;
   assign lk.ninthBit = ninthBit_reg;

endmodule

`default_nettype wire

// *** design/eep_read_path.sv ***
/*
   Protocol engine of a two-wire serial EEPROM read path with its word address counter.
   Assumes an external array answering memAddr on memRdData within one sys_clk cycle,
   and a write engine that takes wrStrobe and reports writeBusy on sys_clk.
*/
`default_nettype none

module eep_read_path
#(
   parameter int ADDR_W = eep_pkg::ADDR_W_DEF
)
(
   // System clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Two-wire bus pins
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Strapped select pins
   input wire logic chipSelectBit0,
   input wire logic chipSelectBit1,
   input wire logic chipSelectBit2,
   // Write engine
   input wire logic writeBusy,
   output logic wrStrobe,
   output logic [ADDR_W-1:0] wrAddr,
   output logic [7:0] wrData,
   // Array read port
   output logic [ADDR_W-1:0] memAddr,
   input wire logic [7:0] memRdData
);

   localparam int SYNC_W = 7;
   localparam int IX_SCL = 6;
   localparam int IX_SDA = 5;
   localparam int IX_BYTE = 1;
   localparam int IX_NINTH = 0;

   eep_link_if lk ();

   eep_link_rx u_rx
   (
      .sclClk(scl),
      .sdaIn(sdaIn),
      .lk(lk.link)
   );

   // ***************************************************************
   // Synchronisers
   // ***************************************************************
   logic [SYNC_W-1:0] syncRaw;
   logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync3_reg;

   assign syncRaw = {scl, sdaIn, chipSelectBit2, chipSelectBit1, chipSelectBit0,
      lk.byteTgl, lk.ninthTgl};

   // The third stage only remembers the previous settled value for edge detection.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end
      else
      begin
         sync1_reg <= syncRaw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   logic sclNow, startEv, stopEv, sclFall, byteEv, ninthEv, devMatch;
   logic [2:0] selPins;

   assign sclNow = sync2_reg[IX_SCL];
   assign selPins = sync2_reg[4:2];
   assign startEv = sclNow & sync3_reg[IX_SCL] & sync3_reg[IX_SDA] & ~sync2_reg[IX_SDA];
   assign stopEv = sclNow & sync3_reg[IX_SCL] & ~sync3_reg[IX_SDA] & sync2_reg[IX_SDA];
   assign sclFall = sync3_reg[IX_SCL] & ~sclNow;

   // ***************************************************************
   // Protocol engine
   // ***************************************************************
   eep_pkg::eep_state_t state_reg, state_next;
   logic [ADDR_W-1:0] addrCnt_reg, addrCnt_next;
   logic [ADDR_W-1:0] wrAddr_reg, wrAddr_next;
   logic [7:0] addrHi_reg, addrHi_next;
   logic [7:0] wrData_reg, wrData_next;
   logic [6:0] txShift_reg, txShift_next;
   logic [2:0] txCnt_reg, txCnt_next;
   logic [2:0] clrCnt_reg, clrCnt_next;
   logic ackPend_reg, ackPend_next;
   logic ackPhase_reg, ackPhase_next;
   logic txArm_reg, txArm_next;
   logic txActive_reg, txActive_next;
   logic sdaOe_reg, sdaOe_next;
   logic linkClr_reg, linkClr_next;
   logic wrStrobe_reg, wrStrobe_next;

   // Toggles jump back to zero while the receiver is cleared; those edges are not bytes.
   assign byteEv = (sync2_reg[IX_BYTE] ^ sync3_reg[IX_BYTE]) & ~linkClr_reg;
   assign ninthEv = (sync2_reg[IX_NINTH] ^ sync3_reg[IX_NINTH]) & ~linkClr_reg;
   assign devMatch = (lk.rxByte[7:4] == eep_pkg::TYPE_CODE) && (lk.rxByte[3:1] == selPins)
      && !writeBusy;

   function automatic logic [ADDR_W-1:0] pageIncr(input logic [ADDR_W-1:0] a);
      logic [eep_pkg::PAGE_BITS-1:0] low;
      low = a[eep_pkg::PAGE_BITS-1:0] + 1'b1;
      return {a[ADDR_W-1:eep_pkg::PAGE_BITS], low};
   endfunction

   always_comb
   begin
      state_next = state_reg;
      addrCnt_next = addrCnt_reg;
      addrHi_next = addrHi_reg;
      wrAddr_next = wrAddr_reg;
      wrData_next = wrData_reg;
      txShift_next = txShift_reg;
      txCnt_next = txCnt_reg;
      clrCnt_next = clrCnt_reg;
      ackPend_next = ackPend_reg;
      ackPhase_next = ackPhase_reg;
      txArm_next = txArm_reg;
      txActive_next = txActive_reg;
      sdaOe_next = sdaOe_reg;
      linkClr_next = linkClr_reg;
      wrStrobe_next = 1'h0;
      if (startEv || stopEv)
      begin
         state_next = startEv ? eep_pkg::ST_DEV : eep_pkg::ST_IDLE;   // [RULE1] [RULE9]
         ackPend_next = 1'h0;
         ackPhase_next = 1'h0;
         txArm_next = 1'h0;
         txActive_next = 1'h0;
         sdaOe_next = 1'h0;
         linkClr_next = 1'h1;
         clrCnt_next = 3'h0;
      end
      else
      begin
         if (linkClr_reg && clrCnt_reg != eep_pkg::CLR_MIN_CYC)
            clrCnt_next = clrCnt_reg + 3'h1;
         if (linkClr_reg && clrCnt_reg == eep_pkg::CLR_MIN_CYC && !sclNow
            && state_reg == eep_pkg::ST_DEV)
            linkClr_next = 1'h0;
         if (byteEv)
         begin
            case (state_reg)
               eep_pkg::ST_DEV:
               begin
                  if (devMatch)   // [RULE15] [RULE18]
                  begin
                     ackPend_next = 1'h1;
                     if (lk.rxByte[0] == eep_pkg::DIR_READ)
                     begin
                        state_next = eep_pkg::ST_READ;   // [RULE1]
                        txArm_next = 1'h1;
                     end
                     else
                        state_next = eep_pkg::ST_WHI;   // [RULE8]
                  end
                  else
                     state_next = eep_pkg::ST_IGNORE;   // [RULE20]
               end
               eep_pkg::ST_WHI:
               begin
                  addrHi_next = lk.rxByte;
                  ackPend_next = 1'h1;
                  state_next = eep_pkg::ST_WLO;
               end
               eep_pkg::ST_WLO:
               begin
                  addrCnt_next = ADDR_W'({addrHi_reg, lk.rxByte});   // [RULE17] [RULE10]
                  ackPend_next = 1'h1;
                  state_next = eep_pkg::ST_WDATA;
               end
               eep_pkg::ST_WDATA:
               begin
                  ackPend_next = 1'h1;
                  wrStrobe_next = 1'h1;
                  wrAddr_next = addrCnt_reg;
                  wrData_next = lk.rxByte;
                  addrCnt_next = pageIncr(addrCnt_reg);   // [RULE5] [RULE2]
               end
               default:
               begin
               end
            endcase
         end
         // The ninth clock of the read address byte carries our own acknowledge, not the master's.
         if (ninthEv && state_reg == eep_pkg::ST_READ && !ackPhase_reg)
         begin
            addrCnt_next = addrCnt_reg + 1'b1;   // [RULE2] [RULE4] [RULE13]
            if (!lk.ninthBit)
               txArm_next = 1'h1;   // [RULE11] [RULE12]
            else
               state_next = eep_pkg::ST_IGNORE;   // [RULE19]
         end
         if (sclFall)
         begin
            if (ackPend_reg)
            begin
               sdaOe_next = 1'h1;   // [RULE16]
               ackPhase_next = 1'h1;
               ackPend_next = 1'h0;
            end
            else if ((ackPhase_reg || !txActive_reg) && txArm_reg)
            begin
               sdaOe_next = ~memRdData[7];   // [RULE6] [RULE10]
               txShift_next = memRdData[6:0];
               txCnt_next = eep_pkg::TX_BITS_LEFT;
               txActive_next = 1'h1;
               txArm_next = 1'h0;
               ackPhase_next = 1'h0;
            end
            else if (ackPhase_reg)
            begin
               sdaOe_next = 1'h0;
               ackPhase_next = 1'h0;
            end
            else if (txActive_reg)
            begin
               if (txCnt_reg != 3'h0)
               begin
                  sdaOe_next = ~txShift_reg[6];   // [RULE6]
                  txShift_next = {txShift_reg[5:0], 1'h0};
                  txCnt_next = txCnt_reg - 3'h1;
               end
               else
               begin
                  sdaOe_next = 1'h0;
                  txActive_next = 1'h0;
               end
            end
         end
      end
   end

   // The counter is deliberately left out of reset: only power loss may lose it.
   always_ff @(posedge sys_clk)
   begin
      addrCnt_reg <= addrCnt_next;   // [RULE3]
      addrHi_reg <= addrHi_next;
      wrAddr_reg <= wrAddr_next;
      wrData_reg <= wrData_next;
      txShift_reg <= txShift_next;
      if (rst)
      begin
         state_reg <= eep_pkg::ST_IDLE;
         txCnt_reg <= 3'h0;
         clrCnt_reg <= 3'h0;
         ackPend_reg <= 1'h0;
         ackPhase_reg <= 1'h0;
         txArm_reg <= 1'h0;
         txActive_reg <= 1'h0;
         sdaOe_reg <= 1'h0;
         linkClr_reg <= 1'h1;
         wrStrobe_reg <= 1'h0;
      end
      else
      begin
         state_reg <= state_next;
         txCnt_reg <= txCnt_next;
         clrCnt_reg <= clrCnt_next;
         ackPend_reg <= ackPend_next;
         ackPhase_reg <= ackPhase_next;
         txArm_reg <= txArm_next;
         txActive_reg <= txActive_next;
         sdaOe_reg <= sdaOe_next;
         linkClr_reg <= linkClr_next;
         wrStrobe_reg <= wrStrobe_next;
      end
   end

   assign lk.linkClr = linkClr_reg;
   assign sdaOut = 1'h0;
   assign sdaOe = sdaOe_reg;
   assign memAddr = addrCnt_reg;
   assign wrStrobe = wrStrobe_reg;
   assign wrAddr = wrAddr_reg;
   assign wrData = wrData_reg;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence devSeen;
      byteEv && !startEv && !stopEv && state_reg == eep_pkg::ST_DEV;
   endsequence

   sequence readNinth;
      ninthEv && !startEv && !stopEv && state_reg == eep_pkg::ST_READ && !ackPhase_reg;
   endsequence

   sequence txLoad;
      sclFall && !startEv && !stopEv && !ackPend_reg && txArm_reg
         && (ackPhase_reg || !txActive_reg);
   endsequence

   select_nack_a: assert property (devSeen and (lk.rxByte[3:1] != selPins) |=> // [RULE20]
      state_reg == eep_pkg::ST_IGNORE && !ackPend_reg)
      else $error("mismatched select bits were acknowledged");
   busy_nack_a: assert property (devSeen and writeBusy |=> !ackPend_reg) // [RULE18]
      else $error("device address acknowledged during a write cycle");
   read_wrap_a: assert property (readNinth and (&addrCnt_reg) |=> addrCnt_reg == '0) // [RULE4]
      else $error("read counter did not wrap to zero");
   seq_incr_a: assert property (readNinth and !lk.ninthBit and !(&addrCnt_reg) |=> // [RULE12]
      addrCnt_reg == $past(addrCnt_reg) + 1'b1 && txArm_reg)
      else $error("acknowledged byte did not advance the counter");
   page_wrap_a: assert property (byteEv && !startEv && !stopEv // [RULE5]
      && state_reg == eep_pkg::ST_WDATA |=> wrStrobe_reg
      && addrCnt_reg[ADDR_W-1:eep_pkg::PAGE_BITS]
      == $past(addrCnt_reg[ADDR_W-1:eep_pkg::PAGE_BITS]))
      else $error("write counter left its page");
   ack_drive_a: assert property (sclFall && ackPend_reg && !startEv && !stopEv |=> // [RULE16]
      sdaOe_reg && ackPhase_reg)
      else $error("acknowledge not driven low");
   msb_first_a: assert property (txLoad |=> sdaOe_reg == ~$past(memRdData[7]) // [RULE6]
      && txCnt_reg == eep_pkg::TX_BITS_LEFT)
      else $error("first output bit is not the byte MSB");
   nack_release_a: assert property (readNinth and lk.ninthBit |=> // [RULE19]
      state_reg == eep_pkg::ST_IGNORE && !txArm_reg)
      else $error("master no-acknowledge did not end the read");
   idle_hold_a: assert property (state_reg == eep_pkg::ST_IDLE && !startEv |=> // [RULE3]
      $stable(addrCnt_reg))
      else $error("counter changed while the bus was idle");
   load_addr_a: assert property (byteEv && !startEv && !stopEv // [RULE17]
      && state_reg == eep_pkg::ST_WLO |=> addrCnt_reg
      == ADDR_W'({$past(addrHi_reg), $past(lk.rxByte)}))
      else $error("word address not loaded into the counter");

endmodule

`default_nettype wire

// *** verification/eep_master_model.sv ***
/*
   Behavioural two-wire bus master that drives SCL and pulls SDA low, one bit slot at a time.
   Assumes the bench resolves the open-drain SDA wire with a pull-up and feeds it back here.
*/
`default_nettype none

module eep_master_model
(
   // Bus lines
   output logic scl,
   output logic sdaLow,
   input wire logic sdaWire
);
   timeunit 1ns;
   timeprecision 100ps;

   // Half of the 160 ns bus clock period; SCL stands still high between frames.
   localparam int HALF = 80;

   initial
   begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end

   // SDA changes only in mid low time, so no bit slot is mistaken for a start or stop.
   task automatic bitSlot(input logic b, output logic seen);
      #(HALF / 2) sdaLow = ~b;
      #(HALF / 2) scl = 1'b1;
      seen = sdaWire;
      #HALF scl = 1'b0;
   endtask

   // Works from idle and, as a repeated start, from inside a frame.
   task automatic startCond();
      if (scl === 1'b0)
      begin
         #(HALF / 2) sdaLow = 1'b0;
         #(HALF / 2) scl = 1'b1;
      end
      #HALF sdaLow = 1'b1;
      #HALF scl = 1'b0;
   endtask

   task automatic stopCond();
      #(HALF / 2) sdaLow = 1'b1;
      #(HALF / 2) scl = 1'b1;
      #HALF sdaLow = 1'b0;
      #(2 * HALF);
   endtask

   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitSlot(d[i], s);
      end
      bitSlot(1'b1, s);
      ack = ~s;
   endtask

   task automatic recvByte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitSlot(1'b1, d[i]);
      end
      bitSlot(~more, s);
   endtask
endmodule

`default_nettype wire

// *** verification/eep_read_path_tb.sv ***
/*
   Self-checking bench for the read path: random, current, sequential reads, refusals, page wrap.
   Assumes the master model in its own file and an array model that answers half a sys_clk cycle after memAddr changes.
*/
`default_nettype none

module eep_read_path_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int AW = 15;
   localparam int TMO = 60000;
   logic sys_clk, rst, scl, sdaLow, sdaWire, sdaOut, sdaOe, writeBusy, wrStrobe;
   logic [2:0] strap;
   logic [AW-1:0] wrAddr, memAddr, cur;
   logic [7:0] wrData, memRdData;
   logic [AW-1:0] wq[$];
   logic [7:0] dq[$];
   int n_fail, tests_run, cyc, seed;

   eep_read_path #(.ADDR_W(AW)) dut (.sys_clk(sys_clk), .rst(rst), .scl(scl), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectBit0(strap[0]), .chipSelectBit1(strap[1]),
      .chipSelectBit2(strap[2]), .writeBusy(writeBusy), .wrStrobe(wrStrobe), .wrAddr(wrAddr),
      .wrData(wrData), .memAddr(memAddr), .memRdData(memRdData));
   eep_master_model m (.scl(scl), .sdaLow(sdaLow), .sdaWire(sdaWire));

   assign sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   function automatic logic [7:0] memByte(input logic [AW-1:0] a);
      return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5A;
   endfunction

   function automatic logic [7:0] devByte(input logic [2:0] s, input logic rd);
      return {eep_pkg::TYPE_CODE, s, rd};
   endfunction

   always @(negedge sys_clk) memRdData <= memByte(memAddr);

   always @(posedge sys_clk)
   begin
      cyc++;
      if (wrStrobe === 1'b1)
      begin
         wq.push_back(wrAddr);
         dq.push_back(wrData);
      end
      if (cyc == TMO)
      begin
         n_fail++;
         $display("ERROR run length expected below %0d seen %0d", TMO, cyc);
         end_sim();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Shifts the bus frame off the system clock grid by a few random nanoseconds.
   task automatic skew();
      #(1 + {$random(seed)} % 9);
   endtask

   task automatic loadAddr(input logic [AW-1:0] a);
      logic k;
      skew();
      m.startCond();
      m.sendByte(devByte(strap, 1'b0), k);
      chk("ack dev write", k, 1'b1);
      m.sendByte({1'b0, a[14:8]}, k);
      chk("ack addr hi", k, 1'b1);
      m.sendByte(a[7:0], k);
      chk("ack addr lo", k, 1'b1);
   endtask

   // Reads n bytes from a, acknowledging all but the last, then stops.
   task automatic readRun(input logic [AW-1:0] a, input int n);
      logic k;
      logic [7:0] d;
      logic [AW-1:0] e;
      skew();
      m.startCond();
      m.sendByte(devByte(strap, 1'b1), k);
      chk("ack dev read", k, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         e = a + AW'(i);
         m.recvByte(i < n - 1, d);
         chk("read data", d, memByte(e));
      end
      m.stopCond();
      cur = a + AW'(n);
      chk("address counter", memAddr, cur);
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      logic k;
      logic [7:0] d, bad[4];
      logic [AW-1:0] a;
      seed = 32'h1E2E;
      rst = 1'b1;
      writeBusy = 1'b0;
      strap = 3'h0;
      memRdData = 8'h00;
      n_fail = 0;
      tests_run = 0;
      cyc = 0;
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      repeat (3) @(negedge sys_clk);
      for (int j = 0; j < 4; j++)
      begin
         @(negedge sys_clk);
         strap = 3'($random(seed));
         a = AW'($random(seed));
         loadAddr(a);
         readRun(a, 1);
      end
      $display("test random read done");
      readRun(cur, 1);
      skew();
      m.startCond();
      m.sendByte(devByte(strap, 1'b1), k);
      m.recvByte(1'b0, d);
      chk("current data", d, memByte(cur));
      m.recvByte(1'b0, d);
      chk("sda released after nack", d, 8'hFF);
      m.stopCond();
      chk("counter after nack", memAddr, cur + 15'h0001);
      cur = cur + 15'h0001;
      $display("test current read done");
      loadAddr(15'h7FFE);
      readRun(15'h7FFE, 4);
      readRun(cur, 3);
      $display("test sequential read done");
      for (int j = 0; j < 3; j++)
      begin
         bad[j] = devByte(strap ^ (3'h1 << j), 1'b1);
      end
      bad[3] = {4'h5, strap, 1'b1};
      for (int j = 0; j < 4; j++)
      begin
         skew();
         m.startCond();
         m.sendByte(bad[j], k);
         chk("nack on wrong address", k, 1'b0);
         m.sendByte(devByte(strap, 1'b1), k);
         chk("ignored until start", k, 1'b0);
         m.stopCond();
      end
      readRun(cur, 1);
      $display("test address mismatch done");
      @(negedge sys_clk);
      writeBusy = 1'b1;
      skew();
      m.startCond();
      m.sendByte(devByte(strap, 1'b1), k);
      chk("nack while busy", k, 1'b0);
      m.stopCond();
      @(negedge sys_clk);
      writeBusy = 1'b0;
      readRun(cur, 1);
      $display("test write busy done");
      wq.delete();
      dq.delete();
      loadAddr(15'h12BF);
      m.sendByte(8'hC3, k);
      chk("ack data 1", k, 1'b1);
      m.sendByte(8'h3C, k);
      chk("ack data 2", k, 1'b1);
      m.stopCond();
      chk("write count", wq.size(), 2);
      if (wq.size() == 2)
      begin
         chk("write addr 1", wq[0], 15'h12BF);
         chk("write data 1", dq[0], 8'hC3);
         chk("write addr wrap", wq[1], 15'h1280);
         chk("write data 2", dq[1], 8'h3C);
      end
      readRun(15'h1281, 1);
      $display("test page wrap done");
      end_sim();
   end
endmodule

`default_nettype wire
